// ===== clk_switch_map.svh
// register map, field positions, reset values and timing counts
`ifndef CLK_SWITCH_MAP_SVH
`define CLK_SWITCH_MAP_SVH

// ************************************************
// register word indices (byte address = 4 * index)
// ************************************************
`define IDX_SUPPLY_MODE 3'h0
`define IDX_OSC_RUN 3'h1
`define IDX_CPU_CLK_SEL 3'h2
`define IDX_SETTLE_SEL 3'h3
`define IDX_SETTLE_STAT 3'h4
`define IDX_LAST 3'h4

// ************************************************
// field positions
// ************************************************
`define SUP_RTCLP_BIT 7
`define SUP_ITMR_BIT 4
`define OSC_MAIN_BIT 7
`define OSC_SUB_BIT 6
`define OSC_ONCHIP_BIT 0
`define CKS_ACTIVE_SUB_BIT 7
`define CKS_SUB_SEL_BIT 6
`define CKS_MAIN_STAT_BIT 5
`define CKS_MAIN_SEL_BIT 4
`define SETTLE_SEL_MSB 2

// ************************************************
// reset values
// ************************************************
`define RST_MAIN_STOP 1'b1
`define RST_SUB_STOP 1'b1
`define RST_ONCHIP_STOP 1'b0
`define RST_SETTLE_SEL 3'h7

// ************************************************
// timing
// ************************************************
`define CLK_PERIOD_NS 25
`define GATE_GAP_NS 50
`define GATE_GAP_CYC ((`GATE_GAP_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
// settle status stages, as powers of two of oscillator periods
`define SETTLE_EXP_0 5'h08
`define SETTLE_EXP_1 5'h09
`define SETTLE_EXP_2 5'h0A
`define SETTLE_EXP_3 5'h0B
`define SETTLE_EXP_4 5'h0D
`define SETTLE_EXP_5 5'h0F
`define SETTLE_EXP_6 5'h11
`define SETTLE_EXP_7 5'h12

`endif

// ===== clk_switch_pkg.sv
// types shared by the clock source switcher
package clk_switch_pkg;

  // clock sources, one-hot, doubling as gate vector
  typedef enum logic [2:0] {
    SRC_ONCHIP = 3'b001,
    SRC_MAIN = 3'b010,
    SRC_SUB = 3'b100
  } src_t;

  typedef enum logic [2:0] {
    SW_IDLE = 3'b001,
    SW_OFF = 3'b010,
    SW_ON = 3'b100
  } sw_state_t;

  typedef struct packed {
    logic main;
    logic sub;
    logic onchip;
  } osc_stop_t;

  typedef struct packed {
    logic rtc_low_power_select;
    logic interval_timer_clock_select;
  } supply_mode_t;

endpackage

// ===== settle_counter.sv
// main oscillator stabilization counter with tick divider
`include "clk_switch_map.svh"

module settle_counter #(
  parameter int TICK_DIV = 4,
  parameter int CNT_W = 19
) (
  // clock and reset
  input wire logic clock,
  input wire logic reset_n,
  // control
  input wire logic run,
  input wire logic [2:0] sel,
  // status
  output logic [7:0] status,
  output logic done
);

  logic [15:0] div_r;
  logic [CNT_W-1:0] cnt_r;
  logic tick;

  // oscillator cycles needed for each status bit, low stage first
  function automatic logic [4:0] stage_exp(input logic [2:0] i);
    case (i)
      3'h0: stage_exp = `SETTLE_EXP_0;
      3'h1: stage_exp = `SETTLE_EXP_1;
      3'h2: stage_exp = `SETTLE_EXP_2;
      3'h3: stage_exp = `SETTLE_EXP_3;
      3'h4: stage_exp = `SETTLE_EXP_4;
      3'h5: stage_exp = `SETTLE_EXP_5;
      3'h6: stage_exp = `SETTLE_EXP_6;
      default: stage_exp = `SETTLE_EXP_7;
    endcase
  endfunction

  function automatic logic reached(input logic [CNT_W-1:0] c, input logic [2:0] i);
    reached = (c >= (CNT_W'(1) << stage_exp(i)));
  endfunction

  // one tick per main oscillator period
  assign tick = run && (div_r == 16'(TICK_DIV - 1));

  always_ff @(posedge clock) begin
    if (!reset_n || !run || tick) begin
      div_r <= 16'h0000;
    end else begin
      div_r <= div_r + 16'h0001;
    end
  end

  // stop counting at the selected wait; a stopped oscillator restarts it
  assign done = reached(cnt_r, sel);

  always_ff @(posedge clock) begin
    if (!reset_n || !run) begin
      cnt_r <= '0;
    end else if (tick && !done) begin
      cnt_r <= cnt_r + CNT_W'(1);
    end
  end

  // status bits fill from the top as the wait elapses
  generate
    for (genvar g = 0; g < 8; g++) begin : g_stat
      assign status[7-g] = reached(cnt_r, 3'(g)); // R14
    end
  endgenerate

endmodule // settle_counter

// ===== cpu_clock_source_switcher.sv
// cpu clock source selection, oscillator control and ahb-lite registers
//
// Notes on behaviour
// (R1) rtc low-power bit set: only rtc and interval timer keep subclock in standby on sub.
// (R2) interval timer clock select set picks the low-speed on-chip oscillator.
// (R3) clearing sub oscillator stop starts it; external clock must already be present.
// (R4) software times the subclock settle itself before selecting it.
// (R5) writing 1 to subclock select moves cpu clock to subclock.
// (R6) active-sub status shows the source; software waits on it before stopping main.
// (R7) on-chip oscillator stop bit: 0 runs it, 1 stops it.
// (R8) software waits 18 to 65 us after starting on-chip oscillator.
// (R9) subclock select cleared with main select 0 returns to on-chip oscillator.
// (R10) after leaving subclock, software sets sub stop and the oscillator stops.
// (R11) software never changes main select while running on subclock.
// (R12) 3-bit settle select picks main wait; 010 gives 2^10 ticks.
// (R13) clearing main oscillator stop starts it; external clock supplied first.
// (R14) settle status bits set in order; 11100000 marks the 010 wait.
// (R15) subclock select cleared with main select 1 goes to high-speed system clock.
// (R16) main source status shows when the high-speed system clock is active.
// (R17) status bits change only after the glitch-free gate switch completes.
//
// Local design decisions: the AHB-Lite slave port and the register offsets.
`include "clk_switch_map.svh"

module cpu_clock_source_switcher #(
  parameter int MAIN_TICK_DIV = 4,
  parameter int SETTLE_CNT_W = 19
) (
  // clock and reset
  input wire logic CLOCK,
  input wire logic RESET_N,
  // ahb-lite slave
  input wire logic HSEL,
  input wire logic [31:0] HADDR,
  input wire logic [1:0] HTRANS,
  input wire logic HWRITE,
  input wire logic [2:0] HSIZE,
  input wire logic [31:0] HWDATA,
  input wire logic HREADY,
  output logic [31:0] HRDATA,
  output logic HREADYOUT,
  output logic HRESP,
  // standby indication from the power controller
  input wire logic STANDBY,
  // oscillator run enables
  output logic MAIN_OSC_RUN,
  output logic SUB_OSC_RUN,
  output logic ONCHIP_OSC_RUN,
  // glitch-free clock gates, one-hot except all low during the switch gap
  output logic MAIN_GATE,
  output logic SUB_GATE,
  output logic ONCHIP_GATE,
  // peripheral clocking
  output logic SUB_PERIPH_RUN,
  output logic ITMR_LOWSPEED_SEL,
  output logic MAIN_SETTLED
);

  localparam int GAP_CYC = `GATE_GAP_CYC;

  // ************************************************
  // declarations
  // ************************************************
  clk_switch_pkg::supply_mode_t supply_r;
  clk_switch_pkg::osc_stop_t stop_r;
  logic sub_sel_r;
  logic main_sel_r;
  logic [2:0] settle_sel_r;
  clk_switch_pkg::src_t active_r;
  logic main_src_r;
  clk_switch_pkg::src_t target_r;
  clk_switch_pkg::src_t req_src;
  clk_switch_pkg::sw_state_t sw_r;
  clk_switch_pkg::sw_state_t sw_nxt;
  logic [7:0] gap_r;
  logic gap_done;
  logic [2:0] gate_r;
  logic wr_pend_r;
  logic [2:0] wr_idx_r;
  logic wr_hit_r;
  logic addr_ok;
  logic rd_take;
  logic [7:0] rd_byte;
  logic [7:0] settle_stat;
  logic settle_done;
  logic [7:0] wbyte;

  // word index valid only inside the five-word window
  function automatic logic decode_ok(input logic [31:0] a);
    decode_ok = (a[31:5] == 27'h0) && (a[4:2] <= `IDX_LAST);
  endfunction

  // ************************************************
  // ahb-lite slave, zero wait states
  // ************************************************
  assign addr_ok = decode_ok(HADDR);
  assign rd_take = HREADY && HSEL && HTRANS[1] && !HWRITE;
  assign wbyte = HWDATA[7:0];

  always_ff @(posedge CLOCK) begin
    if (!RESET_N) begin
      wr_pend_r <= 1'b0;
      wr_idx_r <= 3'h0;
      wr_hit_r <= 1'b0;
    end else if (HREADY) begin
      wr_pend_r <= HSEL && HTRANS[1] && HWRITE;
      wr_idx_r <= HADDR[4:2];
      wr_hit_r <= addr_ok;
    end
  end

  always_ff @(posedge CLOCK) begin
    if (!RESET_N) begin
      HREADYOUT <= 1'b1;
      HRESP <= 1'b0;
    end else begin
      HREADYOUT <= 1'b1;
      HRESP <= 1'b0;
    end
  end

  always_comb begin
    rd_byte = 8'h00;
    case (HADDR[4:2])
      `IDX_SUPPLY_MODE: begin
        rd_byte[`SUP_RTCLP_BIT] = supply_r.rtc_low_power_select;
        rd_byte[`SUP_ITMR_BIT] = supply_r.interval_timer_clock_select;
      end
      `IDX_OSC_RUN: begin
        rd_byte[`OSC_MAIN_BIT] = stop_r.main;
        rd_byte[`OSC_SUB_BIT] = stop_r.sub;
        rd_byte[`OSC_ONCHIP_BIT] = stop_r.onchip;
      end
      `IDX_CPU_CLK_SEL: begin
        rd_byte[`CKS_ACTIVE_SUB_BIT] = (active_r == clk_switch_pkg::SRC_SUB); // R6
        rd_byte[`CKS_SUB_SEL_BIT] = sub_sel_r;
        rd_byte[`CKS_MAIN_STAT_BIT] = main_src_r; // R16
        rd_byte[`CKS_MAIN_SEL_BIT] = main_sel_r;
      end
      `IDX_SETTLE_SEL: begin
        rd_byte[`SETTLE_SEL_MSB:0] = settle_sel_r;
      end
      `IDX_SETTLE_STAT: begin
        rd_byte = settle_stat; // R14
      end
      default: begin
        rd_byte = 8'h00;
      end
    endcase
    if (!addr_ok) begin
      rd_byte = 8'h00;
    end
  end

  // read data captured at the address phase, stands through the data phase
  always_ff @(posedge CLOCK) begin
    if (!RESET_N) begin
      HRDATA <= 32'h0000_0000;
    end else if (rd_take) begin
      HRDATA <= {24'h00_0000, rd_byte};
    end
  end

  // ************************************************
  // software registers
  // ************************************************
  always_ff @(posedge CLOCK) begin
    if (!RESET_N) begin
      supply_r <= '0;
    end else if (wr_pend_r && wr_hit_r && wr_idx_r == `IDX_SUPPLY_MODE) begin
      supply_r.rtc_low_power_select <= wbyte[`SUP_RTCLP_BIT]; // R1
      supply_r.interval_timer_clock_select <= wbyte[`SUP_ITMR_BIT]; // R2
    end
  end

  always_ff @(posedge CLOCK) begin
    if (!RESET_N) begin
      stop_r.main <= `RST_MAIN_STOP;
      stop_r.sub <= `RST_SUB_STOP;
      stop_r.onchip <= `RST_ONCHIP_STOP;
    end else if (wr_pend_r && wr_hit_r && wr_idx_r == `IDX_OSC_RUN) begin
      stop_r.main <= wbyte[`OSC_MAIN_BIT]; // R13
      stop_r.sub <= wbyte[`OSC_SUB_BIT]; // R3 R10
      stop_r.onchip <= wbyte[`OSC_ONCHIP_BIT]; // R7
    end
  end

  // status bits of this word are read-only; writes to them are dropped
  always_ff @(posedge CLOCK) begin
    if (!RESET_N) begin
      sub_sel_r <= 1'b0;
      main_sel_r <= 1'b0;
    end else if (wr_pend_r && wr_hit_r && wr_idx_r == `IDX_CPU_CLK_SEL) begin
      sub_sel_r <= wbyte[`CKS_SUB_SEL_BIT]; // R5
      main_sel_r <= wbyte[`CKS_MAIN_SEL_BIT];
    end
  end

  always_ff @(posedge CLOCK) begin
    if (!RESET_N) begin
      settle_sel_r <= `RST_SETTLE_SEL;
    end else if (wr_pend_r && wr_hit_r && wr_idx_r == `IDX_SETTLE_SEL) begin
      settle_sel_r <= wbyte[`SETTLE_SEL_MSB:0]; // R12
    end
  end

  // ************************************************
  // main oscillator stabilization counter
  // ************************************************
  settle_counter #(
    .TICK_DIV(MAIN_TICK_DIV),
    .CNT_W(SETTLE_CNT_W)
  ) u_settle (
    .clock(CLOCK),
    .reset_n(RESET_N),
    .run(!stop_r.main),
    .sel(settle_sel_r),
    .status(settle_stat),
    .done(settle_done)
  );

  // ************************************************
  // source switch sequencer
  // ************************************************
  // main select only matters once the subclock is deselected
  always_comb begin
    if (sub_sel_r) begin
      req_src = clk_switch_pkg::SRC_SUB; // R5
    end else if (main_sel_r) begin
      req_src = clk_switch_pkg::SRC_MAIN; // R15
    end else begin
      req_src = clk_switch_pkg::SRC_ONCHIP; // R9
    end
  end

  assign gap_done = (gap_r == 8'(GAP_CYC - 1));

  // break before make: all gates low for the gap, then the new one
  always_comb begin
    sw_nxt = sw_r;
    case (sw_r)
      clk_switch_pkg::SW_IDLE: begin
        if (req_src != active_r) begin
          sw_nxt = clk_switch_pkg::SW_OFF;
        end
      end
      clk_switch_pkg::SW_OFF: begin
        if (gap_done) begin
          sw_nxt = clk_switch_pkg::SW_ON;
        end
      end
      clk_switch_pkg::SW_ON: begin
        if (gap_done) begin
          sw_nxt = clk_switch_pkg::SW_IDLE;
        end
      end
      default: begin
        sw_nxt = clk_switch_pkg::SW_IDLE;
      end
    endcase
  end

  always_ff @(posedge CLOCK) begin
    if (!RESET_N) begin
      sw_r <= clk_switch_pkg::SW_IDLE;
    end else begin
      sw_r <= sw_nxt;
    end
  end

  always_ff @(posedge CLOCK) begin
    if (!RESET_N || sw_nxt != sw_r || sw_r == clk_switch_pkg::SW_IDLE) begin
      gap_r <= 8'h00;
    end else begin
      gap_r <= gap_r + 8'h01;
    end
  end

  // target frozen for the whole switch so a late write cannot glitch it
  always_ff @(posedge CLOCK) begin
    if (!RESET_N) begin
      target_r <= clk_switch_pkg::SRC_ONCHIP;
    end else if (sw_r == clk_switch_pkg::SW_IDLE && req_src != active_r) begin
      target_r <= req_src;
    end
  end

  always_ff @(posedge CLOCK) begin
    if (!RESET_N) begin
      gate_r <= clk_switch_pkg::SRC_ONCHIP;
    end else if (sw_nxt == clk_switch_pkg::SW_OFF) begin
      gate_r <= 3'b000;
    end else if (sw_r == clk_switch_pkg::SW_OFF && gap_done) begin
      gate_r <= target_r;
    end
  end

  // status follows only after the new gate has run for the gap
  always_ff @(posedge CLOCK) begin
    if (!RESET_N) begin
      active_r <= clk_switch_pkg::SRC_ONCHIP;
    end else if (sw_r == clk_switch_pkg::SW_ON && gap_done) begin
      active_r <= target_r; // R17
    end
  end

  // main-side status survives a visit to the subclock
  always_ff @(posedge CLOCK) begin
    if (!RESET_N) begin
      main_src_r <= 1'b0;
    end else if (sw_r == clk_switch_pkg::SW_ON && gap_done) begin
      if (target_r != clk_switch_pkg::SRC_SUB) begin
        main_src_r <= (target_r == clk_switch_pkg::SRC_MAIN); // R16 R17
      end
    end
  end

  // ************************************************
  // output flops
  // ************************************************
  always_ff @(posedge CLOCK) begin
    if (!RESET_N) begin
      MAIN_GATE <= 1'b0;
      SUB_GATE <= 1'b0;
      ONCHIP_GATE <= 1'b1;
    end else begin
      MAIN_GATE <= gate_r[1]; // R17
      SUB_GATE <= gate_r[2];
      ONCHIP_GATE <= gate_r[0];
    end
  end

  always_ff @(posedge CLOCK) begin
    if (!RESET_N) begin
      MAIN_OSC_RUN <= 1'b0;
      SUB_OSC_RUN <= 1'b0;
      ONCHIP_OSC_RUN <= 1'b0;
    end else begin
      MAIN_OSC_RUN <= !stop_r.main; // R13
      SUB_OSC_RUN <= !stop_r.sub; // R3 R10
      ONCHIP_OSC_RUN <= !stop_r.onchip; // R7
    end
  end

  // in standby on subclock with low-power select, only rtc and timer keep it
  always_ff @(posedge CLOCK) begin
    if (!RESET_N) begin
      SUB_PERIPH_RUN <= 1'b0;
      ITMR_LOWSPEED_SEL <= 1'b0;
      MAIN_SETTLED <= 1'b0;
    end else begin
      SUB_PERIPH_RUN <= !stop_r.sub && !(supply_r.rtc_low_power_select && STANDBY
                        && active_r == clk_switch_pkg::SRC_SUB); // R1
      ITMR_LOWSPEED_SEL <= supply_r.interval_timer_clock_select; // R2
      MAIN_SETTLED <= settle_done; // R12
    end
  end

endmodule // cpu_clock_source_switcher

// ===== cpu_clock_source_switcher_chk.sv
// port-level assertions for the clock source switcher
module cpu_clock_source_switcher_chk (
  // clock and reset
  input wire logic CLOCK,
  input wire logic RESET_N,
  // bus answer
  input wire logic [31:0] HRDATA,
  input wire logic HREADYOUT,
  input wire logic HRESP,
  // oscillators and gates
  input wire logic SUB_OSC_RUN,
  input wire logic MAIN_GATE,
  input wire logic SUB_GATE,
  input wire logic ONCHIP_GATE,
  input wire logic SUB_PERIPH_RUN
);
  timeunit 1ns;
  timeprecision 1ps;
  wire logic [2:0] g = {MAIN_GATE, SUB_GATE, ONCHIP_GATE};
  default clocking cb @(posedge CLOCK); endclocking
  default disable iff (!RESET_N);
  // ************************************************
  // gate switching
  // ************************************************
  a_gate_one_hot: assert property ($onehot0(g))
    else $error("more than one clock gate open");
  a_gap_then_gate: assert property ($fell(|g) |-> (g == 3'h0)[*2] ##1 $onehot(g))
    else $error("gate gap not two cycles");
  a_gap_bounded: assert property (g == 3'h0 |-> ##[1:2] g != 3'h0)
    else $error("no gate open after gap");
  a_gate_steady: assert property ((|g && $past(|g)) |-> $stable(g))
    else $error("gate changed without gap");
  a_sub_gap: assert property ($rose(SUB_GATE) |-> $past(g, 1) == 3'h0 && $past(g, 2) == 3'h0)
    else $error("subclock gate opened without gap");
  a_reset_onchip: assert property ($rose(RESET_N) |-> g == 3'h1)
    else $error("on-chip gate not open after reset");
  // ************************************************
  // bus and peripherals
  // ************************************************
  a_bus_okay: assert property (HREADYOUT && !HRESP && HRDATA[31:8] == 24'h0)
    else $error("bus answer not ready okay");
  a_periph_needs_osc: assert property (SUB_PERIPH_RUN |-> SUB_OSC_RUN)
    else $error("peripheral subclock without oscillator");
  c_sub: cover property ($rose(SUB_GATE));
  c_main: cover property ($rose(MAIN_GATE));
  c_onchip: cover property ($rose(ONCHIP_GATE));
  c_lowpower: cover property ($fell(SUB_PERIPH_RUN) && SUB_OSC_RUN);
endmodule // cpu_clock_source_switcher_chk

bind cpu_clock_source_switcher cpu_clock_source_switcher_chk u_chk (
  .CLOCK(CLOCK), .RESET_N(RESET_N), .HRDATA(HRDATA), .HREADYOUT(HREADYOUT), .HRESP(HRESP),
  .SUB_OSC_RUN(SUB_OSC_RUN), .MAIN_GATE(MAIN_GATE), .SUB_GATE(SUB_GATE),
  .ONCHIP_GATE(ONCHIP_GATE), .SUB_PERIPH_RUN(SUB_PERIPH_RUN));

// ===== tb_cpu_clock_source_switcher.sv
// self-checking bench for the clock source switcher
module tb_cpu_clock_source_switcher;
  timeunit 1ns;
  timeprecision 1ps;
  logic clock = 1'b0;
  logic reset_n = 1'b0;
  logic hsel = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [31:0] hwdata = 32'h0;
  logic standby = 1'b0;
  logic [31:0] hrdata;
  logic hreadyout, hresp, main_run, sub_run, onchip_run, main_gate, sub_gate, onchip_gate;
  logic periph_run, itmr_sel, settled;
  logic [15:0] lf = 16'h9759;
  logic [7:0] cur = 8'h00;
  logic [7:0] ra[7] = '{8'h00, 8'h04, 8'h08, 8'h0C, 8'h10, 8'h14, 8'h20};
  logic [7:0] rv[7] = '{8'h00, 8'hC0, 8'h00, 8'h07, 8'h00, 8'h00, 8'h00};
  int bad_count = 0;
  int n_tests = 0;
  int n;
  string name_q[$];
  logic [31:0] exp_q[$];
  logic [31:0] got_q[$];

  cpu_clock_source_switcher #(.MAIN_TICK_DIV(1), .SETTLE_CNT_W(19)) u_cpu_clock_source_switcher (
    .CLOCK(clock), .RESET_N(reset_n), .HSEL(hsel), .HADDR(haddr), .HTRANS(htrans),
    .HWRITE(hwrite), .HSIZE(3'h2), .HWDATA(hwdata), .HREADY(hreadyout), .HRDATA(hrdata),
    .HREADYOUT(hreadyout), .HRESP(hresp), .STANDBY(standby), .MAIN_OSC_RUN(main_run),
    .SUB_OSC_RUN(sub_run), .ONCHIP_OSC_RUN(onchip_run), .MAIN_GATE(main_gate),
    .SUB_GATE(sub_gate), .ONCHIP_GATE(onchip_gate), .SUB_PERIPH_RUN(periph_run),
    .ITMR_LOWSPEED_SEL(itmr_sel), .MAIN_SETTLED(settled));

  initial begin
    forever #12.5 clock = ~clock;
  end

  // ************************************************
  // helpers
  // ************************************************
  function automatic logic [15:0] lfsr(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction

  task conclude;
    if (bad_count == 0 && n_tests > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  task check(input string nm, input logic [31:0] g, input logic [31:0] e);
    n_tests++;
    if (g !== e) begin
      $display("BAD %s expected %h seen %h", nm, e, g);
      bad_count++;
    end
  endtask

  // notes an expectation and the value seen; the watcher compares them
  task look(input string nm, input logic [31:0] g, input logic [31:0] e);
    name_q.push_back(nm);
    exp_q.push_back(e);
    got_q.push_back(g);
  endtask

  task edge_rdy;
    int k;
    k = 0;
    @(posedge clock);
    while (hreadyout !== 1'b1 && k < 40) begin
      @(posedge clock);
      k++;
    end
    if (hreadyout !== 1'b1) begin
      bad_count++;
      conclude;
    end
  endtask

  task wr(input logic [7:0] a, input logic [31:0] d);
    hsel <= 1'b1;
    haddr <= {24'h0, a};
    htrans <= 2'h2;
    hwrite <= 1'b1;
    edge_rdy;
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    edge_rdy;
  endtask

  task rd(input string nm, input logic [7:0] a, input logic [31:0] e, input logic [31:0] m);
    hsel <= 1'b1;
    haddr <= {24'h0, a};
    htrans <= 2'h2;
    hwrite <= 1'b0;
    edge_rdy;
    hsel <= 1'b0;
    htrans <= 2'h0;
    edge_rdy;
    look(nm, hrdata & m, e & m);
  endtask

  // status must lag the select until the gate gap is over
  task sw(input logic [7:0] d, input logic [2:0] g, input logic [7:0] s, input logic [7:0] m);
    wr(8'h08, {24'hFFFFFF, d});
    rd("ckc early", 8'h08, {24'h0, cur & 8'hA0 | d & 8'h50}, {24'h0, m});
    repeat (3) @(posedge clock);
    look("gates", {29'h0, main_gate, sub_gate, onchip_gate}, {29'h0, g});
    rd("ckc", 8'h08, {24'h0, s}, {24'h0, m});
    cur = s;
  endtask

  initial begin
    forever begin
      @(negedge clock);
      while (got_q.size() > 0) begin
        check(name_q.pop_front(), got_q.pop_front(), exp_q.pop_front());
      end
    end
  end

  // ************************************************
  // main sequence
  // ************************************************
  initial begin
    repeat (4) @(posedge clock);
    reset_n <= 1'b1;
    wr(8'h14, 32'hFF);
    for (int i = 0; i < 7; i++) rd("reset", ra[i], {24'h0, rv[i]}, 32'hFFFFFFFF);
    look("osc", {29'h0, main_run, sub_run, onchip_run}, 32'h1);
    for (int i = 0; i < 4; i++) begin
      lf = lfsr(lf);
      standby <= lf[1];
      wr(8'h00, {lf, lf});
      rd("supply", 8'h00, {24'h0, lf[7:0] & 8'h90}, 32'hFFFFFFFF);
      look("itmr", {31'h0, itmr_sel}, {31'h0, lf[4]});
    end
    standby <= 1'b0;
    wr(8'h04, 32'hFF);
    rd("osc reg", 8'h04, 32'hC1, 32'hFFFFFFFF);
    look("osc", {29'h0, main_run, sub_run, onchip_run}, 32'h0);
    wr(8'h04, 32'h80);
    repeat (2) @(posedge clock);
    look("osc", {29'h0, main_run, sub_run, onchip_run}, 32'h3);
    // both fresh oscillators get the longest on-chip settle before use
    repeat (2600) @(posedge clock);
    wr(8'h00, 32'h80);
    sw(8'hE0, 3'b010, 8'hC0, 8'hFF);
    standby <= 1'b1;
    repeat (3) @(posedge clock);
    look("periph", {31'h0, periph_run}, 32'h0);
    standby <= 1'b0;
    repeat (3) @(posedge clock);
    look("periph", {31'h0, periph_run}, 32'h1);
    sw(8'h00, 3'b001, 8'h00, 8'hFF);
    wr(8'h0C, 32'h02);
    wr(8'h04, 32'h00);
    rd("settle early", 8'h10, 32'h0, 32'hFFFFFFFF);
    for (n = 0; n < 1300 && settled !== 1'b1; n++) @(posedge clock);
    look("settled", {30'h0, n > 1000, settled}, 32'h3);
    if (settled !== 1'b1) begin
      bad_count++;
      conclude;
    end
    wr(8'h10, 32'hFF);
    repeat (300) @(posedge clock);
    rd("settle", 8'h10, 32'hE0, 32'hFFFFFFFF);
    sw(8'h10, 3'b100, 8'h30, 8'hFF);
    sw(8'h50, 3'b010, 8'hF0, 8'hFF);
    sw(8'h10, 3'b100, 8'h30, 8'hFF);
    wr(8'h04, 32'h41);
    repeat (2) @(posedge clock);
    look("osc", {29'h0, main_run, sub_run, onchip_run}, 32'h4);
    look("periph", {31'h0, periph_run}, 32'h0);
    repeat (2) @(posedge clock);
    conclude;
  end
endmodule // tb_cpu_clock_source_switcher
